// ### sowt_cfg.svh
// register offsets, field positions, reset values and part number
// assumes inclusion by the bus slave and its timer leaf
`ifndef SOWT_CFG_SVH
`define SOWT_CFG_SVH
`define SOWT_OFS_OPTIONS 8'h00
`define SOWT_OFS_CLKOUT 8'h04
`define SOWT_OFS_ID_HIGH 8'h08
`define SOWT_OFS_ID_LOW 8'h0C
`define SOWT_OFS_WAKEUP 8'h10
`define SOWT_OPT_WDOG_EN 7
`define SOWT_OPT_WDOG_LONG 6
`define SOWT_OPT_STOP 5
`define SOWT_CLK_PIN_EN 4
`define SOWT_WK_FLAG 7
`define SOWT_WK_CLEAR 6
`define SOWT_WK_CLKSEL 5
`define SOWT_WK_IRQEN 4
`define SOWT_OPT_RESET 8'hC0
`define SOWT_PART_NUMBER 12'h5A3
`endif

// ### sowt_pkg.sv
// types shared by the options and wakeup timer files
// assumes no surroundings beyond the cfg header
package sowt_pkg;
  typedef enum logic [1:0] {
    SOWT_IDLE = 2'b00,
    SOWT_DATA = 2'b01
  } sowt_phase_t;
  typedef logic [7:0] sowt_byte_t;
endpackage : sowt_pkg

// ### sowt_props.sv
// concurrent checks on the options, clock out, id and wakeup bank ports
// assumes a bind onto sowt_top with the single clk_in domain
`timescale 1ns/1ps
module sowt_props
  import sowt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic stop_request_in,
  input wire logic watchdog_enable_out,
  input wire logic watchdog_long_timeout_out,
  input wire logic stop_permit_out,
  input wire logic stop_enter_out,
  input wire logic illegal_stop_reset_out,
  input wire logic wakeup_irq_out,
  input wire logic clock_out_pin_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [2:0] opts;
  logic moved;
  assign opts = {watchdog_enable_out, watchdog_long_timeout_out, stop_permit_out};
  // cleared one extra cycle so a short reset cannot leave a stale change behind
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !$past(rst_n_in)) moved <= 1'h0;
    else if ($changed(opts)) moved <= 1'h1;
  end
  a_bus_okay: assert property (hreadyout_out && !hresp_out && hrdata_out[31:8] == 24'h0)
    else $error("bus answer not okay");
  a_reset_vals: assert property ($rose(rst_n_in) |-> opts == 3'h6 && !wakeup_irq_out && !clock_out_pin_oe_out)
    else $error("outputs not at reset values");
  a_opt_locked: assert property (moved |-> !$changed(opts))
    else $error("options changed twice");
  a_stop_refused: assert property (stop_request_in && !stop_permit_out |-> ##[1:2] illegal_stop_reset_out)
    else $error("refused stop gave no reset");
  a_stop_taken: assert property (stop_request_in && stop_permit_out |-> ##[1:2] stop_enter_out)
    else $error("permitted stop not entered");
  a_illegal_cause: assert property (illegal_stop_reset_out |-> $past(stop_request_in) || $past(stop_request_in, 2))
    else $error("illegal reset without request");
  a_enter_cause: assert property (stop_enter_out |-> !illegal_stop_reset_out && $past(stop_request_in))
    else $error("stop entered without request");
  a_rdata_holds: assert property (!(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data moved without read");
  c_enter: cover property (stop_enter_out);
  c_illegal: cover property (illegal_stop_reset_out);
  c_irq: cover property ($rose(wakeup_irq_out));
endmodule : sowt_props

// ### sowt_top.sv
// system options, clock output, part id and periodic wakeup registers
// assumes an ahb-lite master with single word transfers; osc and crystal pins async
// Functional notes
// - options register is readable at any time after reset
// - only first options write after reset is taken; later ones ignored
// - options bits 3 and 2 read as zero
// - watchdog enable resets to 1; 1 enables reset on timeout
// - watchdog timeout select resets to 1; 1 long, 0 short
// - stop permit resets to 0; stop then gives illegal opcode reset
// - pin enable gates divided clock onto the clock out pin
// - nonzero divider gives bus clock over twice divider value
// - zero divider with pin enabled holds pin low
// - id high bits 7:4 reserved, writes have no effect
// - fixed read-only 12-bit part number split over high and low
// - wakeup flag sets when wakeup timer times out
// - writing 1 to flag clear clears flag; reads return 0
// - clock select: 0 internal 1 kHz oscillator, 1 external crystal
// - wakeup irq enable gates the wakeup interrupt
// - delay select zero disables wakeup timer
// - internal source periods 8,32,64,128,256,512 ms and 1.024 s
// - external source divides crystal by 256 up to 32768
// - unimplemented wakeup register bits read zero
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "sowt_cfg.svh"
module sowt_top
  import sowt_pkg::*;
#(
  parameter logic [11:0] PART_NUMBER = `SOWT_PART_NUMBER // value is arbitrary
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic osc_1khz_in,
  input wire logic crystal_in,
  input wire logic stop_request_in,
  output logic clock_out_pin_out,
  output logic clock_out_pin_oe_out,
  output logic wakeup_irq_out,
  output logic watchdog_enable_out,
  output logic watchdog_long_timeout_out,
  output logic stop_permit_out,
  output logic stop_enter_out,
  output logic illegal_stop_reset_out
);
  sowt_phase_t phase;
  logic [7:0] wr_addr;
  logic wr_pending;
  logic [2:0] options;
  logic options_locked;
  logic pin_enable;
  logic [2:0] divider;
  logic [2:0] div_count;
  logic div_clock;
  logic flag;
  logic clock_sel;
  logic irq_enable;
  logic [2:0] delay_sel;
  logic osc_s1, osc_s2, osc_s3;
  logic xtal_s1, xtal_s2, xtal_s3;
  logic tick;
  logic timeout;
  logic addr_taken;
  logic [7:0] rd_byte;
  logic wr_now;
  logic clear_now;

  assign addr_taken = hsel_in && hready_in && htrans_in[1];
  assign wr_now = (phase == SOWT_DATA) && wr_pending;

  // zero wait state slave, always okay
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phase <= SOWT_IDLE;
      wr_addr <= 8'h00;
      wr_pending <= 1'b0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      if (addr_taken) begin
        phase <= SOWT_DATA;
        wr_addr <= haddr_in[7:0];
        wr_pending <= hwrite_in;
      end else begin
        phase <= SOWT_IDLE;
        wr_pending <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (haddr_in[7:0])
      `SOWT_OFS_OPTIONS: rd_byte = {options, 5'h00};
      `SOWT_OFS_CLKOUT: rd_byte = {3'h0, pin_enable, 1'b0, divider};
      `SOWT_OFS_ID_HIGH: rd_byte = {4'h0, PART_NUMBER[11:8]};
      `SOWT_OFS_ID_LOW: rd_byte = PART_NUMBER[7:0];
      `SOWT_OFS_WAKEUP: rd_byte = {flag, 1'b0, clock_sel, irq_enable, 1'b0, delay_sel};
      default: rd_byte = 8'h00;
    endcase
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (addr_taken && !hwrite_in) begin
      hrdata_out <= {24'h00_0000, rd_byte};
    end
  end

  // options: write-once until reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      options <= 3'(`SOWT_OPT_RESET >> 5);
      options_locked <= 1'b0;
    end else if (wr_now && wr_addr == `SOWT_OFS_OPTIONS && !options_locked) begin
      options <= {hwdata_in[`SOWT_OPT_WDOG_EN], hwdata_in[`SOWT_OPT_WDOG_LONG], hwdata_in[`SOWT_OPT_STOP]};
      options_locked <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      watchdog_enable_out <= 1'b1;
      watchdog_long_timeout_out <= 1'b1;
      stop_permit_out <= 1'b0;
      stop_enter_out <= 1'b0;
      illegal_stop_reset_out <= 1'b0;
    end else begin
      watchdog_enable_out <= options[2];
      watchdog_long_timeout_out <= options[1];
      stop_permit_out <= options[0];
      // stop request is a one-cycle pulse from core logic on this clock
      stop_enter_out <= stop_request_in && options[0];
      illegal_stop_reset_out <= stop_request_in && !options[0];
    end
  end

  // clock output control
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_enable <= 1'b0;
      divider <= 3'h0;
    end else if (wr_now && wr_addr == `SOWT_OFS_CLKOUT) begin
      pin_enable <= hwdata_in[`SOWT_CLK_PIN_EN];
      divider <= hwdata_in[2:0];
    end
  end

  // toggle every divider cycles: period 2*divider, exact 50 percent
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || divider == 3'h0) begin
      div_count <= 3'h0;
      div_clock <= 1'b0;
    end else if (div_count + 3'h1 >= divider) begin
      div_count <= 3'h0;
      div_clock <= ~div_clock;
    end else begin
      div_count <= div_count + 3'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_out_pin_out <= 1'b0;
      clock_out_pin_oe_out <= 1'b0;
    end else begin
      clock_out_pin_oe_out <= pin_enable;
      clock_out_pin_out <= pin_enable && divider != 3'h0 && div_clock;
    end
  end

  // wakeup source synchronisers and edge detect after second stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_1khz_in;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      xtal_s1 <= crystal_in;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
    end
  end

  // crystal must run below half of clk_in or edges are missed
  assign tick = clock_sel ? (xtal_s2 && !xtal_s3) : (osc_s2 && !osc_s3);

  sowt_wakeup_timer u_timer (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick),
    .clock_sel_in(clock_sel),
    .delay_sel_in(delay_sel),
    .timeout_out(timeout)
  );

  assign clear_now = wr_now && wr_addr == `SOWT_OFS_WAKEUP && hwdata_in[`SOWT_WK_CLEAR];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      clock_sel <= 1'b0;
      irq_enable <= 1'b0;
      delay_sel <= 3'h0;
    end else if (wr_now && wr_addr == `SOWT_OFS_WAKEUP) begin
      clock_sel <= hwdata_in[`SOWT_WK_CLKSEL];
      irq_enable <= hwdata_in[`SOWT_WK_IRQEN];
      delay_sel <= hwdata_in[2:0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      flag <= 1'b0;
    end else if (timeout) begin
      flag <= 1'b1;
    end else if (clear_now) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wakeup_irq_out <= 1'b0;
    end else begin
      wakeup_irq_out <= flag && irq_enable;
    end
  end
endmodule : sowt_top

// ### sowt_wakeup_timer.sv
// periodic wakeup timer: counts selected source ticks and pulses on timeout
// assumes tick inputs are already one-cycle pulses in the clk_in domain
`timescale 1ns/1ps
`include "sowt_cfg.svh"
module sowt_wakeup_timer
  import sowt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire logic clock_sel_in,
  input wire logic [2:0] delay_sel_in,
  output logic timeout_out
);
  logic [14:0] count;
  logic [14:0] limit;
  always_comb begin
    limit = 15'h0000;
    if (clock_sel_in) begin
      case (delay_sel_in)
        3'h1: limit = 15'h00FF;
        3'h2: limit = 15'h03FF;
        3'h3: limit = 15'h07FF;
        3'h4: limit = 15'h0FFF;
        3'h5: limit = 15'h1FFF;
        3'h6: limit = 15'h3FFF;
        3'h7: limit = 15'h7FFF;
        default: limit = 15'h0000;
      endcase
    end else begin
      case (delay_sel_in)
        3'h1: limit = 15'h0007;
        3'h2: limit = 15'h001F;
        3'h3: limit = 15'h003F;
        3'h4: limit = 15'h007F;
        3'h5: limit = 15'h00FF;
        3'h6: limit = 15'h01FF;
        3'h7: limit = 15'h03FF;
        default: limit = 15'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || delay_sel_in == 3'h0) begin
      count <= 15'h0000;
      timeout_out <= 1'b0;
    end else if (tick_in) begin
      if (count >= limit) begin
        count <= 15'h0000;
        timeout_out <= 1'b1;
      end else begin
        count <= count + 15'h0001;
        timeout_out <= 1'b0;
      end
    end else begin
      timeout_out <= 1'b0;
    end
  end
endmodule : sowt_wakeup_timer

// ### system_options_and_wakeup_timer_test.sv
// self-checking bench for the options, clock out, id and wakeup bank
// assumes one zero-wait ahb-lite slave; osc and crystal made here, crystal at clk/4
`timescale 1ns/1ps
module system_options_and_wakeup_timer_test
  import sowt_pkg::*;
;
  localparam logic [11:0] PN = 12'h2B7; // value is arbitrary
  logic clk_in = 0, rst_n_in = 0, hsel_in = 0, hwrite_in = 0, osc_1khz_in = 0, crystal_in = 0, stop_request_in = 0;
  logic [31:0] haddr_in = 0, hwdata_in = 0, hrdata_out;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 3'h2;
  logic hreadyout_out, hresp_out, clock_out_pin_out, clock_out_pin_oe_out, wakeup_irq_out, stop_enter_out;
  logic watchdog_enable_out, watchdog_long_timeout_out, stop_permit_out, illegal_stop_reset_out;
  logic rd_pend = 0;
  logic [15:0] expq[$];
  int mismatches = 0, num_checks = 0, cyc = 0;
  int lim[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
  sowt_top #(.PART_NUMBER(PN)) dut_u (.clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .osc_1khz_in,
    .crystal_in, .stop_request_in, .clock_out_pin_out, .clock_out_pin_oe_out, .wakeup_irq_out,
    .watchdog_enable_out, .watchdog_long_timeout_out, .stop_permit_out, .stop_enter_out, .illegal_stop_reset_out);
  initial forever #12.5 clk_in = ~clk_in;
  // osc tick every 8 cycles, crystal every 4: keeps long delays short
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    osc_1khz_in <= cyc[2];
    crystal_in <= cyc[1];
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic stall;
    mismatches++;
    conclude();
  endtask : stall
  task automatic hwait;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'h1 && n < 50);
    if (hreadyout_out !== 1'h1) stall();
  endtask : hwait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel_in <= 1'h1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hwait();
    htrans_in <= 2'h0;
    hsel_in <= 1'h0;
    hwdata_in <= {24'h0, d};
    rd_pend <= !w;
    hwait();
    rd_pend <= 1'h0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    expq.push_back({m, e});
    xfer(1'h0, a, 8'h00);
  endtask : rd
  // read data taken at the data phase edge, oldest note first
  always @(posedge clk_in) begin
    if (rd_pend && hreadyout_out && expq.size() > 0) begin
      chk(hrdata_out & {24'h0, expq[0][15:8]}, {24'h0, expq[0][7:0]});
      void'(expq.pop_front());
    end
  end
  task automatic lvl(input logic v, output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (clock_out_pin_out === v && n < 40);
    if (n >= 40) stall();
  endtask : lvl
  task automatic irqwait(input int l, output int n);
    n = 0;
    while (wakeup_irq_out === 1'h1 && n < l) begin
      @(posedge clk_in);
      n++;
    end
    while (wakeup_irq_out !== 1'h1 && n < l) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= l) stall();
  endtask : irqwait
  task automatic wk(input logic cs, input int code);
    int per, n;
    logic [7:0] c;
    c = {2'h1, cs, 2'h2, code[2:0]};
    per = lim[code] * (cs ? 128 : 8);
    xfer(1'h1, 8'h10, c);
    irqwait(per * 2 + 64, n);
    rd(8'h10, c ^ 8'hC0);
    xfer(1'h1, 8'h10, c);
    irqwait(per * 2, n);
    chk(n > per - 16 && n < per + 8, 1);
  endtask : wk
  initial begin
    logic [7:0] r;
    int hi, lo;
    void'($urandom(51));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'h1;
    rd(8'h00, 8'hC0);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h00);
    xfer(1'h1, 8'h08, 8'hFF);
    rd(8'h08, {4'h0, PN[11:8]}, 8'h0F);
    rd(8'h0C, PN[7:0]);
    rd(8'h14, 8'h00);
    $display("test reset_id done");
    for (int k = 0; k < 2; k++) begin
      r = 8'($urandom());
      r[5] = k[0];
      xfer(1'h1, 8'h00, r);
      xfer(1'h1, 8'h00, ~r);
      rd(8'h00, r & 8'hE0);
      repeat (2) @(posedge clk_in);
      chk({watchdog_enable_out, watchdog_long_timeout_out, stop_permit_out}, r[7:5]);
      stop_request_in <= 1'h1;
      @(posedge clk_in);
      stop_request_in <= 1'h0;
      hi = 0;
      lo = 0;
      repeat (3) begin
        @(posedge clk_in);
        hi += stop_enter_out;
        lo += illegal_stop_reset_out;
      end
      chk({hi[1:0], lo[1:0]}, k ? 4'h4 : 4'h1);
      rst_n_in <= 1'h0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'h1;
    end
    $display("test options done");
    for (int d = 1; d < 8; d++) begin
      xfer(1'h1, 8'h04, 8'h10 | d[7:0]);
      rd(8'h04, 8'h10 | d[7:0]);
      lvl(1'h1, hi);
      lvl(1'h0, hi);
      lvl(1'h1, hi);
      lvl(1'h0, lo);
      chk({hi[7:0], lo[7:0], clock_out_pin_oe_out}, {d[7:0], d[7:0], 1'h1});
    end
    xfer(1'h1, 8'h04, 8'h10);
    repeat (4) @(posedge clk_in);
    hi = 0;
    repeat (40) begin
      @(posedge clk_in);
      hi += clock_out_pin_out;
    end
    chk(hi, 0);
    xfer(1'h1, 8'h04, 8'h03);
    repeat (3) @(posedge clk_in);
    chk(clock_out_pin_oe_out, 0);
    $display("test clock_out done");
    for (int c = 1; c < 8; c++) wk(1'h0, c);
    for (int c = 1; c < 3; c++) wk(1'h1, c);
    xfer(1'h1, 8'h10, 8'h41);
    repeat (150) @(posedge clk_in);
    chk(wakeup_irq_out, 0);
    rd(8'h10, 8'h81);
    xfer(1'h1, 8'h10, 8'h10);
    repeat (3) @(posedge clk_in);
    chk(wakeup_irq_out, 1);
    xfer(1'h1, 8'h10, 8'h50);
    repeat (200) @(posedge clk_in);
    chk(wakeup_irq_out, 0);
    rd(8'h10, 8'h10);
    $display("test wakeup done");
    conclude();
  end
endmodule : system_options_and_wakeup_timer_test
bind sowt_top sowt_props chk_u (.clk_in, .rst_n_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in, .hrdata_out,
  .hreadyout_out, .hresp_out, .stop_request_in, .watchdog_enable_out, .watchdog_long_timeout_out,
  .stop_permit_out, .stop_enter_out, .illegal_stop_reset_out, .wakeup_irq_out, .clock_out_pin_oe_out);
